// *** decoder_sync_luma_pkg.sv ***
package decoder_sync_luma_pkg;

    // subaddresses of the three setting bytes
    localparam logic [7:0] sync_setup_addr = 8'h08;
    localparam logic [7:0] luma_setup_addr = 8'h09;
    localparam logic [7:0] brightness_level_addr = 8'h0a;

    // reset values: auto field, fast locking, loop closed, normal vertical, trap filter active, comb filter off
    localparam logic [7:0] sync_setup_reset = 8'h98;
    localparam logic [7:0] luma_setup_reset = 8'h00;
    localparam logic [7:0] brightness_level_reset = 8'h80;
    localparam logic [7:0] unmapped_read_value = 8'h00;

    // field positions inside the sync and luma bytes
    localparam int sync_auto_bit = 7;
    localparam int sync_select_bit = 6;
    localparam int sync_toggle_bit = 5;
    localparam int sync_horiz_lsb = 3;
    localparam int sync_loop_bit = 2;
    localparam int sync_vnoise_lsb = 0;
    localparam int luma_bypass_bit = 7;
    localparam int luma_comb_bit = 6;
    localparam int luma_delay_bit = 5;
    localparam int luma_remod_bit = 4;
    localparam int luma_sharp_lsb = 0;

    // horizontal time constant and vertical noise codes
    localparam logic [1:0] horiz_tv_code = 2'h0;
    localparam logic [1:0] horiz_vtr_code = 2'h1;
    localparam logic [1:0] horiz_fast_code = 2'h3;
    localparam logic [1:0] vnoise_normal_code = 2'h0;
    localparam logic [1:0] vnoise_fast_code = 2'h1;
    localparam logic [1:0] vnoise_free_code = 2'h2;

    // sharpness code boundaries
    localparam logic [3:0] sharp_plain_code = 4'h0;
    localparam logic [3:0] sharp_first_notch = 4'hd;

    // added line delay: one line at 525 lines, two at 625 lines
    localparam logic [1:0] delay_lines_60hz = 2'h1;
    localparam logic [1:0] delay_lines_50hz = 2'h2;
    localparam logic [1:0] delay_lines_none = 2'h0;

    typedef enum logic [1:0] {h_tv, h_vtr, h_fast, h_reserved} horiz_mode_type;
    typedef enum logic [1:0] {v_normal, v_fast, v_free, v_bypass} vert_mode_type;
    typedef enum logic [1:0] {filt_plain, filt_peaking, filt_lowpass} filter_kind_type;

    typedef struct packed {
        logic auto_field_detect;
        logic field_standard_select;
        logic forced_field_toggle;
        logic [1:0] horiz_time_constant;
        logic horiz_loop_open;
        logic [1:0] vert_noise_mode;
    } sync_setup_type;

    typedef struct packed {
        logic trap_comb_bypass;
        logic adaptive_comb_enable;
        logic extra_line_delay;
        logic remod_bandwidth_wide;
        logic [3:0] sharpness_select;
    } luma_setup_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_access_type;

    typedef struct packed {
        logic trap_active;
        logic comb_active;
        logic remod_bandwidth_wide;
        logic [1:0] extra_delay_lines;
        filter_kind_type filter_kind;
        logic [2:0] filter_step;
        logic notch_enable;
    } luma_path_type;

endpackage

// *** sharpness_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
module sharpness_decoder
(
    // sharpness code in
    input wire logic [3:0] i_code,
    // decoded filter shape
    output var decoder_sync_luma_pkg::filter_kind_type o_kind,
    output logic [2:0] o_step,
    output logic o_notch
);
    import decoder_sync_luma_pkg::*;

    // step grows with code: peaking gets weaker, low-pass gets stronger
    always_comb
    begin
        o_step = i_code[2:0];
        o_notch = 1'b0;
        if (i_code == sharp_plain_code)
        begin
            o_kind = filt_plain; // R13
        end
        else if (!i_code[3])
        begin
            o_kind = filt_peaking; // R13
            o_step = i_code[2:0] - 3'h1;
        end
        else
        begin
            o_kind = filt_lowpass; // R14
            o_notch = (i_code >= sharp_first_notch); // R14
        end
    end

endmodule // sharpness_decoder
`default_nettype wire

// *** decoder_sync_luma_control.sv ***
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R1] auto bit set: field standard detected automatically
// [R2] manual select: 0 is 50 Hz, 1 is 60 Hz
// [R3] parity toggles on interlace, or always when forced
// [R4] horizontal constant: TV, VTR, reserved, fast locking
// [R5] host prefers fast locking or VTR mode
// [R6] loop open bit fixes horizontal frequency
// [R7] vertical mode: normal, fast, free running, bypass
// [R8] host clears auto detect with vertical fast
// [R9] bypass bit disables trap and comb filtering
// [R10] comb bit picks comb over trap
// [R11] extra delay: one line NTSC, two PAL
// [R12] remodulation bit widens notch, narrows luma
// [R13] sharpness 0 plain, 1 to 7 peaking
// [R14] sharpness 8 to 15 low-pass, notches last
// [R15] brightness unsigned byte, 128 nominal level
// [R16] bytes hold value, apply two cycles after write
module decoder_sync_luma_control
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // subaddressed register port
    input wire decoder_sync_luma_pkg::reg_access_type i_reg,
    output logic [7:0] o_read_data,
    // video timing status
    input wire logic i_field_pulse,
    input wire logic i_source_interlaced,
    input wire logic i_detected_60hz,
    // sync processing settings
    output logic o_field_60hz,
    output logic o_field_parity,
    output var decoder_sync_luma_pkg::horiz_mode_type o_horiz_mode,
    output logic o_horiz_loop_open,
    output var decoder_sync_luma_pkg::vert_mode_type o_vert_mode,
    // luma processing settings
    output var decoder_sync_luma_pkg::luma_path_type o_luma,
    output logic [7:0] o_brightness_offset
);
    import decoder_sync_luma_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // setting bytes

    sync_setup_type sync_reg;
    sync_setup_type next_sync_reg;
    luma_setup_type luma_reg;
    luma_setup_type next_luma_reg;
    logic [7:0] bright_reg;
    logic [7:0] next_bright_reg;
    logic [7:0] next_read_data;
    logic [7:0] wr_data;

    assign wr_data = i_reg.data;

    always_comb
    begin
        next_sync_reg = sync_reg;
        next_luma_reg = luma_reg;
        next_bright_reg = bright_reg;
        next_read_data = o_read_data;
        if (i_reg.write)
        begin
            case (i_reg.addr)
                sync_setup_addr: next_sync_reg = sync_setup_type'(i_reg.data); // R16
                luma_setup_addr: next_luma_reg = luma_setup_type'(i_reg.data); // R16
                brightness_level_addr: next_bright_reg = i_reg.data; // R16
                default: ; // unmapped writes are dropped
            endcase
        end
        if (i_reg.read)
        begin
            case (i_reg.addr)
                sync_setup_addr: next_read_data = sync_reg;
                luma_setup_addr: next_read_data = luma_reg;
                brightness_level_addr: next_read_data = bright_reg;
                default: next_read_data = unmapped_read_value;
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            sync_reg <= sync_setup_type'(sync_setup_reset);
            luma_reg <= luma_setup_type'(luma_setup_reset);
            bright_reg <= brightness_level_reset;
            o_read_data <= unmapped_read_value;
        end
        else
        begin
            sync_reg <= next_sync_reg;
            luma_reg <= next_luma_reg;
            bright_reg <= next_bright_reg;
            o_read_data <= next_read_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // applied settings, one cycle behind the stored bytes

    logic next_field_60hz;
    logic next_field_parity;
    horiz_mode_type next_horiz_mode;
    vert_mode_type next_vert_mode;
    luma_path_type next_luma;
    filter_kind_type sharp_kind;
    logic [2:0] sharp_step;
    logic sharp_notch;

    sharpness_decoder u_sharpness
    (
        .i_code(luma_reg.sharpness_select),
        .o_kind(sharp_kind),
        .o_step(sharp_step),
        .o_notch(sharp_notch)
    );

    always_comb
    begin
        // manual select is ignored while auto detect is on
        next_field_60hz = sync_reg.auto_field_detect ? i_detected_60hz // R1
                                                     : sync_reg.field_standard_select; // R2
        // progressive sources keep parity still unless the toggle is forced
        next_field_parity = o_field_parity ^ (i_field_pulse
            & (i_source_interlaced | sync_reg.forced_field_toggle)); // R3
        case (sync_reg.horiz_time_constant)
            horiz_tv_code: next_horiz_mode = h_tv; // R4
            horiz_vtr_code: next_horiz_mode = h_vtr; // R4
            horiz_fast_code: next_horiz_mode = h_fast; // R4
            default: next_horiz_mode = h_reserved;
        endcase
        case (sync_reg.vert_noise_mode)
            vnoise_normal_code: next_vert_mode = v_normal; // R7
            vnoise_fast_code: next_vert_mode = v_fast; // R7
            vnoise_free_code: next_vert_mode = v_free; // R7
            default: next_vert_mode = v_bypass; // R7
        endcase
        next_luma.trap_active = !luma_reg.trap_comb_bypass
                                && !luma_reg.adaptive_comb_enable; // R9 R10
        next_luma.comb_active = !luma_reg.trap_comb_bypass
                                && luma_reg.adaptive_comb_enable; // R9 R10
        next_luma.remod_bandwidth_wide = luma_reg.remod_bandwidth_wide; // R12
        // 60 Hz is taken as the NTSC family, 50 Hz as PAL
        if (!luma_reg.extra_line_delay)
            next_luma.extra_delay_lines = delay_lines_none; // R11
        else if (next_field_60hz)
            next_luma.extra_delay_lines = delay_lines_60hz; // R11
        else
            next_luma.extra_delay_lines = delay_lines_50hz; // R11
        next_luma.filter_kind = sharp_kind; // R13 R14
        next_luma.filter_step = sharp_step;
        next_luma.notch_enable = sharp_notch; // R14
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            o_field_60hz <= 1'b0;
            o_field_parity <= 1'b0;
            o_horiz_mode <= h_fast;
            o_horiz_loop_open <= 1'b0;
            o_vert_mode <= v_normal;
            o_luma <= '0;
            o_brightness_offset <= brightness_level_reset;
        end
        else
        begin
            o_field_60hz <= next_field_60hz;
            o_field_parity <= next_field_parity;
            o_horiz_mode <= next_horiz_mode;
            o_horiz_loop_open <= sync_reg.horiz_loop_open; // R6
            o_vert_mode <= next_vert_mode;
            o_luma <= next_luma;
            o_brightness_offset <= bright_reg; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    sequence sync_write_s;
        i_reg.write && i_reg.addr == sync_setup_addr;
    endsequence

    sequence bright_write_s;
        i_reg.write && i_reg.addr == brightness_level_addr;
    endsequence

    sync_hold_a: assert property (!(i_reg.write && i_reg.addr == sync_setup_addr) |=> $stable(sync_reg)) // R16
        else $error("sync byte changed without a write");

    loop_apply_a: assert property (sync_write_s |-> ##2 o_horiz_loop_open == $past(wr_data[sync_loop_bit], 2)) // R6
        else $error("loop open not applied two cycles after write");

    bright_apply_a: assert property (bright_write_s |-> ##2 o_brightness_offset == $past(wr_data, 2)) // R15
        else $error("brightness not applied two cycles after write");

    field_std_a: assert property (1'b1 |=> o_field_60hz == ($past(sync_reg.auto_field_detect)
        ? $past(i_detected_60hz) : $past(sync_reg.field_standard_select))) // R1
        else $error("field standard does not follow auto or manual select");

    parity_still_a: assert property (!(i_field_pulse && (i_source_interlaced
        || sync_reg.forced_field_toggle)) |=> $stable(o_field_parity)) // R3
        else $error("field parity toggled without cause");

    parity_forced_a: assert property (i_field_pulse && sync_reg.forced_field_toggle
        |=> o_field_parity != $past(o_field_parity)) // R3
        else $error("forced field toggle missed");

    horiz_reserved_a: assert property (sync_reg.horiz_time_constant == 2'h2 |=> o_horiz_mode == h_reserved) // R4
        else $error("reserved horizontal code mapped wrongly");

    vert_bypass_a: assert property (sync_reg.vert_noise_mode == 2'h3 |=> o_vert_mode == v_bypass) // R7
        else $error("vertical bypass not selected");

    filter_bypass_a: assert property (luma_reg.trap_comb_bypass |=> !o_luma.trap_active && !o_luma.comb_active) // R9
        else $error("filter active while bypassed");

    line_delay_a: assert property ($past(luma_reg.extra_line_delay) |-> o_luma.extra_delay_lines
        == (o_field_60hz ? delay_lines_60hz : delay_lines_50hz)) // R11
        else $error("extra line delay wrong for standard");

    sharp_notch_a: assert property (luma_reg.sharpness_select >= 4'hd
        |=> o_luma.notch_enable && o_luma.filter_kind == filt_lowpass) // R14
        else $error("notch missing on strongest low-pass codes");

endmodule // decoder_sync_luma_control
`default_nettype wire

// *** host_cfg_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_cfg_model
(
    // clock
    input wire logic i_clock,
    // subaddressed register port
    output var decoder_sync_luma_pkg::reg_access_type o_reg,
    input wire logic [7:0] i_read_data
);
    import decoder_sync_luma_pkg::*;

    // set by a scenario that must reach the legacy horizontal mode on purpose
    bit legacy_tv = 1'b0;

    initial o_reg = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // d comes back as the byte really sent, so the bench models what the device saw
    task automatic wr(input logic [7:0] a, inout logic [7:0] d);
        if (a == sync_setup_addr && d[4:3] == horiz_tv_code && !legacy_tv)
            d[4:3] = horiz_fast_code;
        if (a == sync_setup_addr && d[1:0] == vnoise_fast_code)
            d[sync_auto_bit] = 1'b0;
        @(posedge i_clock);
        o_reg <= '{write: 1'b1, read: 1'b0, addr: a, data: d};
        @(posedge i_clock);
        // idle lines carry the inverse, so a stale byte cannot pass for a fresh one
        o_reg <= '{write: 1'b0, read: 1'b0, addr: ~a, data: ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_reg.read <= 1'b1;
        o_reg.addr <= a;
        @(posedge i_clock);
        o_reg.read <= 1'b0;
        @(negedge i_clock);
        d = i_read_data;
    endtask
endmodule // host_cfg_model
`default_nettype wire

// *** decoder_sync_luma_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module decoder_sync_luma_control_tb;
    import decoder_sync_luma_pkg::*;

    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic field_pulse = 1'b0;
    logic interlaced = 1'b0;
    logic det60 = 1'b0;
    reg_access_type bus;
    logic [7:0] rdata, bright_out, got, r;
    logic f60, parity, loop_open;
    horiz_mode_type hmode;
    vert_mode_type vmode;
    luma_path_type luma;
    logic [7:0] m_sync = sync_setup_reset;
    logic [7:0] m_luma = luma_setup_reset;
    logic [7:0] m_bright = brightness_level_reset;
    logic m_par = 1'b0;
    logic [31:0] seed = 32'h084bf1d5;
    logic [7:0] lv [4] = '{8'h00, 8'h80, 8'hff, 8'h5a};
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    decoder_sync_luma_control dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_reg(bus),
        .o_read_data(rdata), .i_field_pulse(field_pulse), .i_source_interlaced(interlaced),
        .i_detected_60hz(det60), .o_field_60hz(f60), .o_field_parity(parity),
        .o_horiz_mode(hmode), .o_horiz_loop_open(loop_open), .o_vert_mode(vmode),
        .o_luma(luma), .o_brightness_offset(bright_out));
    host_cfg_model host (.i_clock(i_clock), .o_reg(bus), .i_read_data(rdata));

    initial
    begin
        forever #20 i_clock = ~i_clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_all();
        logic f;
        horiz_mode_type eh;
        luma_path_type e;
        f = m_sync[sync_auto_bit] ? det60 : m_sync[sync_select_bit];
        eh = m_sync[4:3] == 2'h3 ? h_fast : m_sync[4:3] == 2'h2 ? h_reserved
            : horiz_mode_type'(m_sync[4:3]);
        e = '0;
        e.trap_active = !m_luma[7] && !m_luma[6];
        e.comb_active = !m_luma[7] && m_luma[6];
        e.remod_bandwidth_wide = m_luma[4];
        e.extra_delay_lines = !m_luma[5] ? delay_lines_none
            : f ? delay_lines_60hz : delay_lines_50hz;
        e.filter_kind = m_luma[3] ? filt_lowpass : m_luma[2:0] != 3'h0 ? filt_peaking : filt_plain;
        if (m_luma[3])
            e.filter_step = m_luma[2:0];
        else if (m_luma[2:0] != 3'h0)
            e.filter_step = m_luma[2:0] - 3'h1;
        e.notch_enable = m_luma[3:0] >= 4'hd;
        chk("field_60hz", 16'(f), 16'(f60));
        chk("horiz_mode", 16'(eh), 16'(hmode));
        chk("loop_open", 16'(m_sync[2]), 16'(loop_open));
        chk("vert_mode", 16'(m_sync[1:0]), 16'(vmode));
        chk("luma_path", 16'(e), 16'(luma));
        chk("brightness", 16'(m_bright), 16'(bright_out));
        chk("parity", 16'(m_par), 16'(parity));
    endtask

    // settings are compared one edge after the write lands
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        @(posedge i_clock);
        det60 <= r[0];
        host.wr(a, v);
        if (a == sync_setup_addr)
            m_sync = v;
        if (a == luma_setup_addr)
            m_luma = v;
        if (a == brightness_level_addr)
            m_bright = v;
        @(posedge i_clock);
        @(negedge i_clock);
        check_all();
    endtask

    task automatic get(input logic [7:0] a);
        host.rd(a, got);
        chk("read_data", 16'(a == sync_setup_addr ? m_sync : a == luma_setup_addr ? m_luma
            : a == brightness_level_addr ? m_bright : unmapped_read_value), 16'(got));
    endtask

    task automatic field(input logic il);
        @(posedge i_clock);
        field_pulse <= 1'b1;
        interlaced <= il;
        @(posedge i_clock);
        field_pulse <= 1'b0;
        if (il || m_sync[sync_toggle_bit])
            m_par = !m_par;
        @(negedge i_clock);
        check_all();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        r = 8'h00;
        repeat (6) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        @(negedge i_clock);
        check_all();
        for (int a = 7; a <= 11; a++) get(8'(a));
        host.legacy_tv = 1'b1;
        for (int k = 0; k < 32; k++)
        begin
            r = 8'(rnd());
            put(sync_setup_addr, {r[7:5], 5'(k)});
        end
        host.legacy_tv = 1'b0;
        for (int k = 0; k < 256; k++)
        begin
            r = 8'(rnd());
            put(luma_setup_addr, 8'(k));
        end
        foreach (lv[i]) put(brightness_level_addr, lv[i]);
        put(8'h0b, 8'h3c);
        put(8'h07, 8'hc3);
        put(sync_setup_addr, 8'h18);
        field(1'b0);
        field(1'b1);
        put(sync_setup_addr, 8'h38);
        field(1'b0);
        field(1'b1);
        repeat (60)
        begin
            r = 8'(rnd());
            put(8'h08 + 8'(seed[9:8]), r);
            get(8'h08 + 8'(seed[11:10]));
        end
        wrap_up();
    end

    // the run needs about 1600 cycles; a hang is cut well beyond that
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            wrap_up();
        end
    end
endmodule // decoder_sync_luma_control_tb
`default_nettype wire
